// ---- timer_table_wake_move_decode_test.sv ----
// Purpose: Self-checking bench for the wake, timer-load and pointer-move group.
// Assumes: Data memory is modelled as a fixed nibble pattern of the read address.
// Notes:   Instructions are issued back to back; results are checked one cycle later.
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------------------
module timer_table_wake_move_decode_test;
    logic        mclk_i  = 1'b0;
    logic        srst_i  = 1'b1;
    logic        exec_i  = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic [6:0]  dmem_addr_o;
    logic [3:0]  dmem_rdata_i;
    logic        claim_o, acc_flag_we_o, timer_a_start_o, timer_b_start_o;
    logic [3:0]  wake_o, t0l, t0h, t1l, t1h, tbl, tbh;
    logic [7:0]  timer_a_value_o, timer_b_value_o;
    int          failures = 0;
    int          checked  = 0;
    logic [6:0]  addrs [6] = '{7'h7f, 7'h40, 7'h05, 7'h3a, 7'h01, 7'h66};
    logic [8:0]  pfx   [6];
    logic [23:0] exp_nibs;

    // Half period of 12.5 ns gives the 40 MHz machine clock.
    always #12.5 mclk_i = ~mclk_i;

    // Memory model: a pattern that differs for every address bit, bit 6 included.
    function automatic logic [3:0] mem(input logic [6:0] a);
        return a[3:0] ^ {1'b0, a[6:4]} ^ 4'h6;
    endfunction : mem
    assign dmem_rdata_i = mem(dmem_addr_o);

    ttwd_core ttwd_core_inst (
        .mclk_i(mclk_i), .srst_i(srst_i), .exec_i(exec_i), .instr_i(instr_i),
        .dmem_addr_o(dmem_addr_o), .dmem_rdata_i(dmem_rdata_i), .claim_o(claim_o),
        .acc_flag_we_o(acc_flag_we_o), .stop_wake_edge_enable_o(wake_o),
        .timer_a_start_o(timer_a_start_o), .timer_a_value_o(timer_a_value_o),
        .timer0_low_nibble_o(t0l), .timer0_high_nibble_o(t0h),
        .timer_b_start_o(timer_b_start_o), .timer_b_value_o(timer_b_value_o),
        .timer1_low_nibble_o(t1l), .timer1_high_nibble_o(t1h),
        .table_pointer_low_o(tbl), .table_pointer_high_o(tbh));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Presents one word for a cycle; claim is combinational so it is checked here.
    task automatic issue(input logic [15:0] w, input logic e, input logic c);
        @(posedge mclk_i);
        exec_i  <= e;
        instr_i <= w;
        #1;
        check("claim", {7'h00, claim_o}, {7'h00, c});
        check("acc_flag_we", {7'h00, acc_flag_we_o}, 8'h00);
    endtask : issue

    // Drops exec so the last issued word is taken and its result has landed.
    task automatic settle();
        @(posedge mclk_i);
        exec_i <= 1'b0;
        #1;
    endtask : settle

    task automatic check_nibs(input logic [23:0] exp);
        logic [23:0] seen;
        seen = {t0l, t0h, t1l, t1h, tbl, tbh};
        for (int k = 0; k < 6; k++) begin
            check("nibble", {4'h0, seen[23-4*k -: 4]}, {4'h0, exp[23-4*k -: 4]});
        end
    endtask : check_nibs

    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    // Watchdog: the sequence needs well under 200 cycles.
    initial begin
        #(25 * 2000);
        failures++;
        give_verdict();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        pfx = '{ttwd_pkg::OP_T0_LOW, ttwd_pkg::OP_T0_HIGH, ttwd_pkg::OP_T1_LOW,
                ttwd_pkg::OP_T1_HIGH, ttwd_pkg::OP_TAB_LOW, ttwd_pkg::OP_TAB_HIGH};
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'b0;
        #1;
        check_nibs(24'h000000);
        check("wake rst", {4'h0, wake_o}, 8'h00);
        // Each wake bit alone, then a mix; the last word, with a non-zero nibble, is refused.
        foreach (addrs[k]) begin
            issue({12'h520, 4'h1 << k[1:0]}, 1'b1, 1'b1);
            settle();
            check("wake", {4'h0, wake_o}, {4'h0, 4'h1 << k[1:0]});
        end
        issue(16'h520b, 1'b1, 1'b1);
        issue(16'h5214, 1'b1, 1'b0);
        settle();
        check("wake mix", {4'h0, wake_o}, 8'h0b);
        // All six moves back to back, with a valid word ignored while exec is low.
        for (int k = 0; k < 6; k++) begin
            issue({pfx[k], addrs[k]}, 1'b1, 1'b1);
            check("addr", {1'b0, dmem_addr_o}, {1'b0, addrs[k]});
            exp_nibs[23-4*k -: 4] = mem(addrs[k]);
        end
        issue({ttwd_pkg::OP_T0_LOW, 7'h00}, 1'b0, 1'b0);
        settle();
        check_nibs(exp_nibs);
        // Timer loads back to back; start pulses last one cycle each.
        issue(16'h10a5, 1'b1, 1'b1);
        issue(16'h11ff, 1'b1, 1'b1);
        check("a start", {7'h00, timer_a_start_o}, 8'h01);
        check("a value", timer_a_value_o, 8'ha5);
        settle();
        check("a start off", {7'h00, timer_a_start_o}, 8'h00);
        check("b start", {7'h00, timer_b_start_o}, 8'h01);
        check("b value", timer_b_value_o, 8'hff);
        settle();
        check("b start off", {7'h00, timer_b_start_o}, 8'h00);
        check("a hold", timer_a_value_o, 8'ha5);
        check_nibs(exp_nibs);
        // The same timer reloaded back to back keeps its strobe high.
        issue(16'h103c, 1'b1, 1'b1);
        issue(16'h1001, 1'b1, 1'b1);
        check("a value 3c", timer_a_value_o, 8'h3c);
        settle();
        check("a restart", {7'h00, timer_a_start_o}, 8'h01);
        check("a value 01", timer_a_value_o, 8'h01);
        // Reset in mid-run clears every stored value.
        @(posedge mclk_i);
        srst_i <= 1'b1;
        @(posedge mclk_i);
        srst_i <= 1'b0;
        #1;
        check_nibs(24'h000000);
        check("wake clr", {4'h0, wake_o}, 8'h00);
        check("b clr", timer_b_value_o, 8'h00);
        check("a clr", timer_a_value_o, 8'h00);
        check("a start clr", {7'h00, timer_a_start_o}, 8'h00);
        // A word right after reset is taken normally.
        issue(16'h5205, 1'b1, 1'b1);
        settle();
        check("wake after rst", {4'h0, wake_o}, 8'h05);
        give_verdict();
    end
endmodule : timer_table_wake_move_decode_test

// ---- ttwd_core.sv ----
// Purpose: Executes wake-enable, timer-load and pointer-move instructions.
// Assumes: exec_i marks one machine cycle; memory read data is same-cycle.
// Notes:   Timer and table logic sit outside; this block feeds them.
// Operation
// [RULE_01] Wake-enable opcode with zero nibble, one cycle.
// [RULE_02] Each immediate bit enables one line's wake.
// [RULE_03] Timer A immediate load and start.
// [RULE_04] Memory nibble into timer A low.
// [RULE_05] Memory nibble into timer A high.
// [RULE_06] Timer B immediate load and start.
// [RULE_07] Memory nibble into timer B low.
// [RULE_08] Memory nibble into timer B high.
// [RULE_09] Memory nibble into table pointer low.
// [RULE_10] Memory nibble into table pointer high.
// [RULE_11] Source address is low seven bits.
// [RULE_12] Accumulator and zero flag stay untouched.
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Core
// ----------------------------------------------------------------------------
module ttwd_core (
    // Clock and reset.
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // Instruction stream.
    input  wire logic        exec_i,
    input  wire logic [15:0] instr_i,
    // Data memory read port.
    output logic      [6:0]  dmem_addr_o,
    input  wire logic [3:0]  dmem_rdata_i,
    // Core hand-off.
    output logic             claim_o,
    output logic             acc_flag_we_o,
    // Stop-mode wake enables.
    output logic      [3:0]  stop_wake_edge_enable_o,
    // Countdown timer A.
    output logic             timer_a_start_o,
    output logic      [7:0]  timer_a_value_o,
    output logic      [3:0]  timer0_low_nibble_o,
    output logic      [3:0]  timer0_high_nibble_o,
    // Countdown timer B.
    output logic             timer_b_start_o,
    output logic      [7:0]  timer_b_value_o,
    output logic      [3:0]  timer1_low_nibble_o,
    output logic      [3:0]  timer1_high_nibble_o,
    // Table pointer.
    output logic      [3:0]  table_pointer_low_o,
    output logic      [3:0]  table_pointer_high_o
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] wake;
        logic       a_start;
        logic [7:0] a_val;
        logic [3:0] a_lo;
        logic [3:0] a_hi;
        logic       b_start;
        logic [7:0] b_val;
        logic [3:0] b_lo;
        logic [3:0] b_hi;
        logic [3:0] tab_lo;
        logic [3:0] tab_hi;
    } ttwd_state_t;

    ttwd_state_t          st_ff;
    ttwd_state_t          nxt_st;
    ttwd_pkg::ttwd_op_t   op;
    logic [7:0]           imm8;
    logic [3:0]           imm4;

    ttwd_decode ttwd_decode_inst (
        .instr_i (instr_i),
        .op_o    (op)
    );

    // Immediate fields and memory address are plain slices of the word.
    assign imm8        = instr_i[ttwd_pkg::IMM_LSB +: ttwd_pkg::IMM8_W];
    assign imm4        = instr_i[ttwd_pkg::IMM_LSB +: ttwd_pkg::NIB_W];
    assign dmem_addr_o = instr_i[ttwd_pkg::ADDR_LSB +: ttwd_pkg::ADDR_W]; // [RULE_11]

    // The core must not write the accumulator or zero flag for a claimed word.
    assign claim_o       = exec_i && (op != ttwd_pkg::OPK_NONE);
    assign acc_flag_we_o = 1'b0; // [RULE_12]

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // Start strobes last one cycle; nibble registers hold until rewritten.
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.a_start = 1'b0;
        nxt_st.b_start = 1'b0;
        if (exec_i) begin
            case (op)
                ttwd_pkg::OPK_WAKE_EN: begin
                    nxt_st.wake = imm4; // [RULE_02]
                end
                ttwd_pkg::OPK_T0_LOAD: begin
                    nxt_st.a_val   = imm8; // [RULE_03]
                    nxt_st.a_start = 1'b1;
                end
                ttwd_pkg::OPK_T1_LOAD: begin
                    nxt_st.b_val   = imm8; // [RULE_06]
                    nxt_st.b_start = 1'b1;
                end
                ttwd_pkg::OPK_T0_LOW:   nxt_st.a_lo   = dmem_rdata_i; // [RULE_04]
                ttwd_pkg::OPK_T0_HIGH:  nxt_st.a_hi   = dmem_rdata_i; // [RULE_05]
                ttwd_pkg::OPK_T1_LOW:   nxt_st.b_lo   = dmem_rdata_i; // [RULE_07]
                ttwd_pkg::OPK_T1_HIGH:  nxt_st.b_hi   = dmem_rdata_i; // [RULE_08]
                ttwd_pkg::OPK_TAB_LOW:  nxt_st.tab_lo = dmem_rdata_i; // [RULE_09]
                ttwd_pkg::OPK_TAB_HIGH: nxt_st.tab_hi = dmem_rdata_i; // [RULE_10]
                default: begin
                    nxt_st = nxt_st;
                end
            endcase
        end
    end

    // Register the whole state; every field clears on reset.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_ff <= '{wake: ttwd_pkg::RST_NIB, a_start: 1'b0, a_val: ttwd_pkg::RST_BYTE,
                       a_lo: ttwd_pkg::RST_NIB, a_hi: ttwd_pkg::RST_NIB, b_start: 1'b0,
                       b_val: ttwd_pkg::RST_BYTE, b_lo: ttwd_pkg::RST_NIB,
                       b_hi: ttwd_pkg::RST_NIB, tab_lo: ttwd_pkg::RST_NIB,
                       tab_hi: ttwd_pkg::RST_NIB};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state flip-flops.
    assign stop_wake_edge_enable_o = st_ff.wake;
    assign timer_a_start_o         = st_ff.a_start;
    assign timer_a_value_o         = st_ff.a_val;
    assign timer0_low_nibble_o     = st_ff.a_lo;
    assign timer0_high_nibble_o    = st_ff.a_hi;
    assign timer_b_start_o         = st_ff.b_start;
    assign timer_b_value_o         = st_ff.b_val;
    assign timer1_low_nibble_o     = st_ff.b_lo;
    assign timer1_high_nibble_o    = st_ff.b_hi;
    assign table_pointer_low_o     = st_ff.tab_lo;
    assign table_pointer_high_o    = st_ff.tab_hi;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    // Executed word whose top nine bits match a register-move prefix.
    sequence s_exec9(logic [8:0] pfx);
        exec_i && instr_i[15:ttwd_pkg::PFX9_LSB] == pfx;
    endsequence

    // Executed word whose top eight bits match an immediate timer load.
    sequence s_exec8(logic [7:0] pfx);
        exec_i && instr_i[15:ttwd_pkg::PFX8_LSB] == pfx;
    endsequence

    // Executed wake-enable word, its zero nibble included.
    sequence s_exec_wake;
        exec_i && instr_i[15:ttwd_pkg::PFX12_LSB] == ttwd_pkg::OP_WAKE_EN;
    endsequence

    // A start strobe drops after one cycle unless the next word reloads the same timer.
    sequence s_a_end;
        !timer_a_start_o
            || $past(exec_i && instr_i[15:ttwd_pkg::PFX8_LSB] == ttwd_pkg::OP_T0_LOAD);
    endsequence

    sequence s_b_end;
        !timer_b_start_o
            || $past(exec_i && instr_i[15:ttwd_pkg::PFX8_LSB] == ttwd_pkg::OP_T1_LOAD);
    endsequence

    // Wake enables: loaded in one cycle, refused with a non-zero nibble, held otherwise.
    // The reset cycle is left out of the hold check, since reset itself clears them.
    AST_WAKE_ONE_CYCLE: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_01]
        s_exec_wake |=> stop_wake_edge_enable_o == $past(instr_i[3:0]))
        else $error("Wake enables not loaded in one cycle.");
    AST_WAKE_REFUSE: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_01]
        exec_i && instr_i[15:8] == ttwd_pkg::OP_WAKE_EN[11:4] && instr_i[7:4] != 4'h0
        |-> !claim_o)
        else $error("Wake word with non-zero nibble was claimed.");
    AST_WAKE_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_02]
        !srst_i && !(exec_i && instr_i[15:ttwd_pkg::PFX12_LSB] == ttwd_pkg::OP_WAKE_EN)
        |=> $stable(stop_wake_edge_enable_o))
        else $error("Wake enables changed without their instruction.");

    // Immediate timer loads: value and strobe in one cycle, nibbles untouched.
    AST_T0_LOAD: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_03]
        s_exec8(ttwd_pkg::OP_T0_LOAD) |=> timer_a_start_o && !timer_b_start_o
            && timer_a_value_o == $past(instr_i[7:0]) ##1 s_a_end)
        else $error("Timer A load or start strobe wrong.");
    AST_LOAD_KEEPS_NIBS: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_03]
        s_exec8(ttwd_pkg::OP_T0_LOAD) |=> $stable({timer0_low_nibble_o, timer0_high_nibble_o}))
        else $error("Timer A immediate load altered its nibbles.");
    AST_IDLE_NO_START: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_06]
        !exec_i |=> !timer_a_start_o && !timer_b_start_o)
        else $error("Timer start strobe without an executed word.");

    // Register moves and the timer B load: the nibble or byte lands in its target one cycle later.
    AST_T0_LOW: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_04]
        s_exec9(ttwd_pkg::OP_T0_LOW) |=> timer0_low_nibble_o == $past(dmem_rdata_i))
        else $error("Timer A low nibble not copied.");
    AST_T0_HIGH: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_05]
        s_exec9(ttwd_pkg::OP_T0_HIGH) |=> timer0_high_nibble_o == $past(dmem_rdata_i)
            && $stable(timer0_low_nibble_o))
        else $error("Timer A high nibble not copied.");
    AST_T1_LOAD: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_06]
        s_exec8(ttwd_pkg::OP_T1_LOAD) |=> timer_b_start_o && !timer_a_start_o
            && timer_b_value_o == $past(instr_i[7:0]) ##1 s_b_end)
        else $error("Timer B load or start strobe wrong.");
    AST_T1_LOW: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_07]
        s_exec9(ttwd_pkg::OP_T1_LOW) |=> timer1_low_nibble_o == $past(dmem_rdata_i))
        else $error("Timer B low nibble not copied.");
    AST_T1_HIGH: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_08]
        s_exec9(ttwd_pkg::OP_T1_HIGH) |=> timer1_high_nibble_o == $past(dmem_rdata_i))
        else $error("Timer B high nibble not copied.");
    AST_TAB: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_09]
        s_exec9(ttwd_pkg::OP_TAB_LOW) |=> table_pointer_low_o == $past(dmem_rdata_i)
            && $stable(table_pointer_high_o))
        else $error("Table pointer low nibble not copied.");
    AST_TABLE_POINTER_HIGH: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_10]
        s_exec9(ttwd_pkg::OP_TAB_HIGH) |=> table_pointer_high_o == $past(dmem_rdata_i))
        else $error("Table pointer high nibble not copied.");

    // Address and flag side effects for any claimed word.
    AST_ADDR: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_11]
        claim_o |-> dmem_addr_o == instr_i[6:0])
        else $error("Memory address not taken from low seven bits.");
    AST_NO_FLAG: assert property (@(posedge mclk_i) disable iff (srst_i) // [RULE_12]
        claim_o |-> !acc_flag_we_o)
        else $error("Accumulator write requested for a claimed word.");
endmodule : ttwd_core

// ---- ttwd_decode.sv ----
// Purpose: Combinational opcode match for the move group.
// Assumes: Instruction word is stable for the whole machine cycle.
// Notes:   Returns OPK_NONE for any word outside this group.
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Decoder
// ----------------------------------------------------------------------------
module ttwd_decode (
    // Instruction in.
    input  wire logic [15:0]       instr_i,
    // Decoded operation out.
    output ttwd_pkg::ttwd_op_t     op_o
);
    logic [11:0] pfx12;
    logic [7:0]  pfx8;
    logic [8:0]  pfx9;

    // Prefix slices of the instruction word.
    assign pfx12 = instr_i[15:ttwd_pkg::PFX12_LSB];
    assign pfx8  = instr_i[15:ttwd_pkg::PFX8_LSB];
    assign pfx9  = instr_i[15:ttwd_pkg::PFX9_LSB];

    // Match the prefixes; the groups never overlap, so order is free.
    always_comb begin
        op_o = ttwd_pkg::OPK_NONE;
        if (pfx12 == ttwd_pkg::OP_WAKE_EN) begin                 // [RULE_01]
            op_o = ttwd_pkg::OPK_WAKE_EN;
        end else if (pfx8 == ttwd_pkg::OP_T0_LOAD) begin         // [RULE_03]
            op_o = ttwd_pkg::OPK_T0_LOAD;
        end else if (pfx8 == ttwd_pkg::OP_T1_LOAD) begin         // [RULE_06]
            op_o = ttwd_pkg::OPK_T1_LOAD;
        end else begin
            case (pfx9)
                ttwd_pkg::OP_T0_LOW:   op_o = ttwd_pkg::OPK_T0_LOW;   // [RULE_04]
                ttwd_pkg::OP_T0_HIGH:  op_o = ttwd_pkg::OPK_T0_HIGH;  // [RULE_05]
                ttwd_pkg::OP_T1_LOW:   op_o = ttwd_pkg::OPK_T1_LOW;   // [RULE_07]
                ttwd_pkg::OP_T1_HIGH:  op_o = ttwd_pkg::OPK_T1_HIGH;  // [RULE_08]
                ttwd_pkg::OP_TAB_LOW:  op_o = ttwd_pkg::OPK_TAB_LOW;  // [RULE_09]
                ttwd_pkg::OP_TAB_HIGH: op_o = ttwd_pkg::OPK_TAB_HIGH; // [RULE_10]
                default:               op_o = ttwd_pkg::OPK_NONE;
            endcase
        end
    end
endmodule : ttwd_decode

// ---- ttwd_pkg.sv ----
// Purpose: Shared constants and types for the timer, table and wake move decoder.
// Assumes: 16-bit instruction words, 4-bit data memory, 7-bit data address.
// Notes:   Opcode prefixes are matched against the top bits of the instruction.
// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package ttwd_pkg;
    // Field widths.
    localparam int unsigned INSTR_W  = 16;
    localparam int unsigned ADDR_W   = 7;
    localparam int unsigned NIB_W    = 4;
    localparam int unsigned IMM8_W   = 8;
    // Field positions.
    localparam int unsigned ADDR_LSB = 0;
    localparam int unsigned IMM_LSB  = 0;
    localparam int unsigned PFX12_LSB = 4;
    localparam int unsigned PFX8_LSB  = 8;
    localparam int unsigned PFX9_LSB  = 7;
    // Opcode prefixes.
    localparam logic [11:0] OP_WAKE_EN  = 12'h520;
    localparam logic [7:0]  OP_T0_LOAD  = 8'h10;
    localparam logic [7:0]  OP_T1_LOAD  = 8'h11;
    localparam logic [8:0]  OP_T0_LOW   = 9'h028;
    localparam logic [8:0]  OP_T0_HIGH  = 9'h029;
    localparam logic [8:0]  OP_T1_LOW   = 9'h02a;
    localparam logic [8:0]  OP_T1_HIGH  = 9'h02b;
    localparam logic [8:0]  OP_TAB_LOW  = 9'h130;
    localparam logic [8:0]  OP_TAB_HIGH = 9'h131;
    // Reset values.
    localparam logic [3:0]  RST_NIB     = 4'h0;
    localparam logic [7:0]  RST_BYTE    = 8'h00;

    // Operations recognised by this group.
    typedef enum logic [3:0] {
        OPK_NONE,
        OPK_WAKE_EN,
        OPK_T0_LOAD,
        OPK_T1_LOAD,
        OPK_T0_LOW,
        OPK_T0_HIGH,
        OPK_T1_LOW,
        OPK_T1_HIGH,
        OPK_TAB_LOW,
        OPK_TAB_HIGH
    } ttwd_op_t;
endpackage : ttwd_pkg
